// [logic/sdv_serializer.v]
// Purpose: parallel video to scrambled NRZI serial stream, plus port
// Assumes: pin inputs synchronous to i_core_clk; video and port clocks
//          are sampled pins, detected by edge
// Notes: one serial bit per bit_en enable; video words buffer in a FIFO
`timescale 1ns/10ps
`include "sdv_map.vh"

// word FIFO with valid/ready on both sides
module sdv_fifo #(
  parameter WIDTH = 20,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  // honest flags from the fill count
  assign o_in_ready = (count != DEPTH[AW:0]);
  assign o_out_valid = (count != {(AW+1){1'b0}});
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  // pointer and count upkeep
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                  : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                  : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end

  // storage, no reset needed
  always @(posedge i_core_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end
endmodule

// How it works
// - capture 10 or 20-bit word per video clock
// - HD: luma upper ten, chroma lower ten
// - SD: both samples interleaved on lower ten
// - delay stages, depth from three-bit field
// - detect raster, store five-bit detected code
// - nonzero forced code overrides; reset gives auto
// - Standard_def_restrict and High_def_restrict bits restrict detection
// - clip 000-003 to 000, 3FC-3FF to 3FF
// - clipping happens before scrambling
// - dither enable bit turns on LSB dither
// - vertical blanking dither needs its own bit
// - both dither bits reset off
// - scramble with x^9 + x^4 + 1
// - serialize least significant bit first
// - NRZI: toggle output for every one bit
// - ten bits per SD word, twenty per HD
// - target select picks ancillary FIFO or registers
// - direction picks register read or write
// - register access works at any slow rate
// - port edges act only on selected target
// - lock after detection or a forced code, and only with PLL lock
// - tags: 00 address, 11 write data, 10 read
// - read data driven until next port edge with target low
module sdv_serializer #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3,
  parameter BIT_DIV = 1
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_pixel_word_clock,
  input wire [19:0] i_video_in_bus,
  output wire o_video_ready,
  input wire i_vert_blank,
  input wire i_pll_locked,
  input wire i_port_clock,
  input wire i_port_target,
  input wire i_port_dir,
  input wire [9:0] i_port_data,
  output reg [9:0] o_port_data,
  output reg o_port_oe,
  output reg o_anc_valid,
  output reg [9:0] o_anc_data,
  output reg o_serial_line_out,
  output wire o_lock_detect
);
  localparam P_ADDR = 2'h0;
  localparam P_WDATA = 2'h1;
  localparam P_RDRV = 2'h2;

  // pin synchronisers and edge detection
  reg pck_s1, pck_s2, pck_s3;
  reg prt_s1, prt_s2, prt_s3;
  reg [19:0] vid_d1, vid_d2;
  reg [11:0] pctl_d1, pctl_d2;
  wire pix_edge = pck_s2 & ~pck_s3;
  wire port_edge = prt_s2 & ~prt_s3;
  wire [9:0] pdat = pctl_d2[9:0];
  wire ptgt = pctl_d2[10];
  wire pdir = pctl_d2[11];

  // configuration state
  reg [7:0] fmt_ctrl;
  reg [2:0] depth;
  reg dith_en, vdith_en;
  reg [1:0] pst;
  reg [7:0] paddr;
  reg [7:0] rd_val;

  // input register and delay stages
  reg [19:0] in_word;
  reg word_evt;
  reg [19:0] dly [0:3];
  reg [2:0] vcnt;
  reg [19:0] tap;
  wire fifo_in_ready;
  wire push_valid = word_evt & (vcnt >= depth);

  // detector state
  reg hd_lane;
  reg [1:0] trs_st;
  reg [11:0] wcnt;
  reg [11:0] last_len;
  reg [4:0] det_code;
  reg det_ok;
  reg [4:0] next_code;
  wire [9:0] lane_word = hd_lane ? in_word[19:10] : in_word[9:0];
  wire [4:0] force_code = fmt_ctrl[`SDV_FORCE_LSB +: 5];
  wire standard_def_restrict = fmt_ctrl[`SDV_STANDARD_DEF_RESTRICT_BIT];
  wire high_def_restrict = fmt_ctrl[`SDV_HIGH_DEF_RESTRICT_BIT];
  wire [4:0] fmt_act = (force_code != `SDV_FMT_NONE) ? force_code
                       : det_code;
  wire hd_mode = (fmt_act >= `SDV_FMT_HD_MIN);

  // encoder state
  wire fifo_out_valid;
  wire [19:0] fifo_out_data;
  reg [19:0] shreg;
  reg [4:0] bcnt;
  reg [8:0] scr;
  reg [15:0] lfsr;
  reg [7:0] div_cnt;
  wire bit_en = (div_cnt == 8'h00);
  wire load = bit_en & (bcnt == 5'h00);
  wire scr_bit = shreg[0] ^ scr[3] ^ scr[8];
  wire dith_now = dith_en & (~i_vert_blank | vdith_en);
  wire [9:0] enc_lo;
  wire [9:0] enc_hi;

  assign o_lock_detect = (det_ok | (force_code != `SDV_FMT_NONE))
                         & i_pll_locked;
  assign o_video_ready = fifo_in_ready;

  // clip out-of-range timing values, then dither the rest
  function [9:0] enc10;
    input [9:0] w;
    input dith;
    input rnd;
    begin
      if (w <= `SDV_CLIP_LO_MAX) begin
        enc10 = `SDV_TRS_LO;
      end else if (w >= `SDV_CLIP_HI_MIN) begin
        enc10 = `SDV_TRS_HI;
      end else begin
        enc10 = {w[9:1], w[0] ^ (dith & rnd)};
      end
    end
  endfunction

  // sample the clock pins and their data together
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pck_s1 <= 1'b0;
      pck_s2 <= 1'b0;
      pck_s3 <= 1'b0;
      prt_s1 <= 1'b0;
      prt_s2 <= 1'b0;
      prt_s3 <= 1'b0;
      vid_d1 <= 20'h00000;
      vid_d2 <= 20'h00000;
      pctl_d1 <= 12'h000;
      pctl_d2 <= 12'h000;
    end else begin
      pck_s1 <= i_pixel_word_clock;
      pck_s2 <= pck_s1;
      pck_s3 <= pck_s2;
      prt_s1 <= i_port_clock;
      prt_s2 <= prt_s1;
      prt_s3 <= prt_s2;
      vid_d1 <= i_video_in_bus;
      vid_d2 <= vid_d1;
      pctl_d1 <= {i_port_dir, i_port_target, i_port_data};
      pctl_d2 <= pctl_d1;
    end
  end

  // port read value select
  always @* begin
    rd_val = 8'h00;
    if (paddr == `SDV_REG_FMT_CTRL) begin
      rd_val = fmt_ctrl;
    end else if (paddr == `SDV_REG_FMT_STAT) begin
      rd_val = {o_lock_detect, 2'h0, det_code};
    end else if (paddr == `SDV_REG_ANC_CFG) begin
      rd_val = {5'h00, depth};
    end else if (paddr == `SDV_REG_PIC_INFO) begin
      rd_val = {6'h00, vdith_en, dith_en};
    end
  end

  // port protocol; each edge counts, however slow the clock is
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pst <= P_ADDR;
      paddr <= 8'h00;
      fmt_ctrl <= `SDV_FMT_CTRL_RST;
      depth <= `SDV_ANC_CFG_RST;
      dith_en <= 1'b0;
      vdith_en <= 1'b0;
      o_port_oe <= 1'b0;
      o_port_data <= 10'h000;
      o_anc_valid <= 1'b0;
      o_anc_data <= 10'h000;
    end else begin
      o_anc_valid <= 1'b0;
      if (port_edge & ptgt) begin
        if (!pdir) begin
          o_anc_valid <= 1'b1;
          o_anc_data <= pdat;
        end
      end else if (port_edge) begin
        case (pst)
          P_RDRV: begin
            o_port_oe <= 1'b0;
            pst <= P_ADDR;
          end
          P_ADDR: begin
            if (pdat[9:8] == `SDV_TAG_ADDR) begin
              paddr <= pdat[7:0];
              pst <= pdir ? P_RDRV : P_WDATA;
            end
          end
          P_WDATA: begin
            if (pdat[9:8] == `SDV_TAG_WDATA) begin
              if (paddr == `SDV_REG_FMT_CTRL) begin
                fmt_ctrl <= {1'b0, pdat[6:0]};
              end else if (paddr == `SDV_REG_ANC_CFG) begin
                depth <= pdat[2:0];
              end else if (paddr == `SDV_REG_PIC_INFO) begin
                dith_en <= pdat[`SDV_DITH_BIT];
                vdith_en <= pdat[`SDV_VDITH_BIT];
              end
              pst <= P_ADDR;
            end else if (pdat[9:8] == `SDV_TAG_ADDR) begin
              paddr <= pdat[7:0];
            end
          end
          default: begin
            pst <= P_ADDR;
          end
        endcase
      end
      // read data appears the cycle after the address is taken
      if (pst == P_RDRV && !o_port_oe) begin
        o_port_oe <= 1'b1;
        o_port_data <= {`SDV_TAG_RDATA, rd_val};
      end
    end
  end

  // input register: full bus, SD uses only the low lane
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in_word <= 20'h00000;
      word_evt <= 1'b0;
    end else begin
      word_evt <= pix_edge;
      if (pix_edge) begin
        in_word <= vid_d2;
      end
    end
  end

  // delay stages, generated per stage
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_dly
      always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          dly[gi] <= 20'h00000;
        end else if (word_evt) begin
          dly[gi] <= (gi == 0) ? in_word : dly[(gi == 0) ? 0 : gi-1];
        end
      end
    end
  endgenerate

  // tap select; depths above four use the fourth stage, but vcnt stops at four so no word is pushed
  always @* begin
    tap = in_word;
    if (depth == 3'h1) begin
      tap = dly[0];
    end else if (depth == 3'h2) begin
      tap = dly[1];
    end else if (depth == 3'h3) begin
      tap = dly[2];
    end else if (depth >= `SDV_MAX_DEPTH) begin
      tap = dly[3];
    end
  end

  // count primed stages so no reset filler is pushed
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vcnt <= 3'h0;
    end else if (word_evt && vcnt < `SDV_MAX_DEPTH) begin
      vcnt <= vcnt + 3'h1;
    end
  end

  // line length to format code for the lane in use
  always @* begin
    next_code = `SDV_FMT_NONE;
    if (!hd_lane && wcnt == `SDV_LEN_SD525) begin
      next_code = `SDV_FMT_SD525;
    end else if (!hd_lane && wcnt == `SDV_LEN_SD625) begin
      next_code = `SDV_FMT_SD625;
    end else if (hd_lane && wcnt == `SDV_LEN_1125_30) begin
      next_code = `SDV_FMT_1125_30;
    end else if (hd_lane && wcnt == `SDV_LEN_1125_25) begin
      next_code = `SDV_FMT_1125_25;
    end else if (hd_lane && wcnt == `SDV_LEN_720_60) begin
      next_code = `SDV_FMT_720_60;
    end
  end

  // raster detector: two equal line lengths between EAVs
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hd_lane <= 1'b0;
      trs_st <= 2'h0;
      wcnt <= 12'h000;
      last_len <= 12'h000;
      det_code <= `SDV_FMT_NONE;
      det_ok <= 1'b0;
    end else begin
      if (standard_def_restrict) begin
        hd_lane <= 1'b0;
      end else if (high_def_restrict) begin
        hd_lane <= 1'b1;
      end
      if (word_evt) begin
        wcnt <= (wcnt == `SDV_WCNT_MAX) ? wcnt : wcnt + 12'h001;
        case (trs_st)
          2'h0: trs_st <= (lane_word == `SDV_TRS_HI) ? 2'h1 : 2'h0;
          2'h1: trs_st <= (lane_word == `SDV_TRS_LO) ? 2'h2 : 2'h0;
          2'h2: trs_st <= (lane_word == `SDV_TRS_LO) ? 2'h3 : 2'h0;
          default: begin
            trs_st <= 2'h0;
            if (lane_word[`SDV_H_BIT]) begin
              wcnt <= 12'h001;
              last_len <= wcnt;
              if (wcnt == last_len && next_code != `SDV_FMT_NONE) begin
                det_code <= next_code;
                det_ok <= 1'b1;
              end else begin
                det_ok <= 1'b0;
              end
            end
          end
        endcase
        if (wcnt == `SDV_WCNT_MAX) begin
          det_ok <= 1'b0;
          wcnt <= 12'h000;
          if (!standard_def_restrict && !high_def_restrict) begin
            hd_lane <= ~hd_lane;
          end
        end
      end
    end
  end

  sdv_fifo #(
    .WIDTH(20),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(push_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(tap),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(load),
    .o_out_data(fifo_out_data)
  );

  assign enc_lo = enc10(fifo_out_data[9:0], dith_now, lfsr[0]);
  assign enc_hi = enc10(fifo_out_data[19:10], dith_now, lfsr[1]);

  // serial bit divider
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_cnt <= 8'h00;
    end else if (div_cnt == BIT_DIV[7:0] - 8'h01) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // load words, shift LSB first, scramble and NRZI per bit
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shreg <= 20'h00000;
      bcnt <= 5'h00;
      scr <= 9'h000;
      lfsr <= 16'hACE1;
      o_serial_line_out <= 1'b0;
    end else if (bit_en) begin
      scr <= {scr[7:0], scr_bit};
      o_serial_line_out <= o_serial_line_out ^ scr_bit;
      if (load) begin
        lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        bcnt <= hd_mode ? 5'd19 : 5'd9;
        if (fifo_out_valid) begin
          // clipped word enters the shifter ahead of the scrambler
          shreg <= hd_mode ? {enc_hi, enc_lo}
                   : {10'h000, enc_lo};
        end else begin
          shreg <= 20'h00000;
        end
      end else begin
        bcnt <= bcnt - 5'h01;
        shreg <= {1'b0, shreg[19:1]};
      end
    end
  end
endmodule

// [shared/sdv_map.vh]
// Purpose: constants for the serial video transmit path
// Assumes: included by logic/sdv_serializer.v
// Notes: port register offsets and format codes live here
`ifndef SDV_MAP_VH
`define SDV_MAP_VH

// control register offsets on the port
`define SDV_REG_FMT_CTRL 8'h00
`define SDV_REG_FMT_STAT 8'h01
`define SDV_REG_ANC_CFG 8'h02
`define SDV_REG_PIC_INFO 8'h03

// field positions
`define SDV_FORCE_LSB 0
`define SDV_STANDARD_DEF_RESTRICT_BIT 5
`define SDV_HIGH_DEF_RESTRICT_BIT 6
`define SDV_LOCK_BIT 7
`define SDV_DITH_BIT 0
`define SDV_VDITH_BIT 1

// reset values
`define SDV_FMT_CTRL_RST 8'h00
`define SDV_ANC_CFG_RST 3'h4
`define SDV_PIC_INFO_RST 2'h0

// port handshake tags on the upper two bits
`define SDV_TAG_ADDR 2'h0
`define SDV_TAG_WDATA 2'h3
`define SDV_TAG_RDATA 2'h2

// timing reference characters and clip bounds
`define SDV_TRS_HI 10'h3FF
`define SDV_TRS_LO 10'h000
`define SDV_CLIP_LO_MAX 10'h003
`define SDV_CLIP_HI_MIN 10'h3FC
`define SDV_H_BIT 4

// words per line for each recognised raster
`define SDV_LEN_SD525 12'h6B4
`define SDV_LEN_SD625 12'h6C0
`define SDV_LEN_1125_30 12'h898
`define SDV_LEN_1125_25 12'hA50
`define SDV_LEN_720_60 12'h672

// format codes; codes from HD_MIN up are 20-bit
`define SDV_FMT_NONE 5'h00
`define SDV_FMT_SD525 5'h01
`define SDV_FMT_SD625 5'h02
`define SDV_FMT_HD_MIN 5'h03
`define SDV_FMT_1125_30 5'h03
`define SDV_FMT_1125_25 5'h04
`define SDV_FMT_720_60 5'h05

// word-count limit before the detector tries the other lane
`define SDV_WCNT_MAX 12'hFFF
`define SDV_MAX_DEPTH 3'h4

`endif

// [tb/sdv_serializer_sva.sv]
// Purpose: port assertions for the serial video path
// Assumes: bench spaces port clock edges 9 cycles apart
// Notes: windows allow for the two-flop pin samplers
`timescale 1ns/10ps
module sdv_serializer_chk (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_pixel_word_clock,
  input wire [19:0] i_video_in_bus,
  input wire o_video_ready,
  input wire i_vert_blank,
  input wire i_pll_locked,
  input wire i_port_clock,
  input wire i_port_target,
  input wire i_port_dir,
  input wire [9:0] i_port_data,
  input wire [9:0] o_port_data,
  input wire o_port_oe,
  input wire o_anc_valid,
  input wire [9:0] o_anc_data,
  input wire o_serial_line_out,
  input wire o_lock_detect
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // register read cycle on the port
  property p_rd_tag;
    o_port_oe |-> o_port_data[9:8] == 2'b10;
  endproperty
  a_rd_tag: assert property (p_rd_tag) else $error("read tag");
  property p_rd_rise;
    $rose(i_port_clock) && !i_port_target && i_port_dir &&
      i_port_data[9:8] == 2'b00 && !o_port_oe |-> ##[2:5] o_port_oe;
  endproperty
  a_rd_rise: assert property (p_rd_rise) else $error("no read");
  property p_rd_hold;
    $rose(o_port_oe) |=> (o_port_oe && $stable(o_port_data))[*3];
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read hold");
  property p_rd_drop;
    $rose(i_port_clock) && !i_port_target && o_port_oe
      |-> ##[2:5] !o_port_oe;
  endproperty
  a_rd_drop: assert property (p_rd_drop) else $error("no release");
  // ancillary words only on target-high writes
  property p_anc_take;
    $rose(i_port_clock) && i_port_target && !i_port_dir
      |-> ##[2:5] o_anc_valid;
  endproperty
  a_anc_take: assert property (p_anc_take) else $error("anc lost");
  property p_anc_quiet;
    $rose(i_port_clock) && (!i_port_target || i_port_dir)
      |=> !o_anc_valid[*5];
  endproperty
  a_anc_quiet: assert property (p_anc_quiet) else $error("anc");
  property p_lock;
    o_lock_detect |-> i_pll_locked;
  endproperty
  a_lock: assert property (p_lock) else $error("lock early");
  property p_rst;
    $rose(i_rst_n) |-> o_video_ready && !o_port_oe && !o_anc_valid;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  c_read: cover property ($rose(o_port_oe));
  c_anc: cover property (o_anc_valid);
  c_full: cover property (!o_video_ready);
endmodule

// [tb/sdv_serializer_test.sv]
// Purpose: self-checking bench for the serial video transmit path
// Assumes: BIT_DIV 1, so one line bit per core clock
// Notes: the line is decoded back to data bits and searched for words
`timescale 1ns/10ps
`include "sdv_map.vh"
module sdv_serializer_test;
  reg clk, rst_n, pll, aclk, tgt, dir, host_en;
  reg [9:0] host_data, anc_last;
  reg [8:0] sh;
  reg [39:0] win, want;
  reg [31:0] seed;
  reg [19:0] w0, w1;
  reg prev_sdo, seen, saw_full, vblank;
  integer fails, checks_done, cycles, anc_cnt, i;
  wire [9:0] port_pad, port_q, anc_data;
  wire [19:0] vbus;
  wire pix, ready, port_oe, anc_valid, serial_line_out, lock;
  // pad level: device while reading, else host, else pull-down
  assign port_pad = port_oe ? port_q : (host_en ? host_data : 10'h000);
  sdv_serializer #(.FIFO_DEPTH(8), .FIFO_AW(3), .BIT_DIV(1))
  i_sdv_serializer (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_pixel_word_clock(pix),
    .i_video_in_bus(vbus), .o_video_ready(ready), .i_vert_blank(vblank),
    .i_pll_locked(pll), .i_port_clock(aclk), .i_port_target(tgt),
    .i_port_dir(dir), .i_port_data(port_pad), .o_port_data(port_q),
    .o_port_oe(port_oe), .o_anc_valid(anc_valid), .o_anc_data(anc_data),
    .o_serial_line_out(serial_line_out), .o_lock_detect(lock));
  sdv_video_src i_sdv_video_src (.i_core_clk(clk), .i_ready(ready),
    .o_pixel_word_clock(pix), .o_video_in_bus(vbus));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // expected word after reference clipping
  function [9:0] clip10(input [9:0] v);
    begin
      if (v <= `SDV_CLIP_LO_MAX) clip10 = `SDV_TRS_LO;
      else if (v >= `SDV_CLIP_HI_MIN) clip10 = `SDV_TRS_HI;
      else clip10 = v;
    end
  endfunction
  task chk(input [8*12-1:0] what, input [19:0] exp, input [19:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[ERR] %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // one slow port clock cycle, pins held well around the rise
  task port_edge(input t, input d, input en, input [9:0] w);
    begin
      tgt <= t;
      dir <= d;
      host_en <= en;
      host_data <= w;
      repeat (2) @(posedge clk);
      aclk <= 1'b1;
      repeat (3) @(posedge clk);
      aclk <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task reg_read(input [7:0] a, input [7:0] exp);
    begin
      port_edge(1'b0, 1'b1, 1'b1, {`SDV_TAG_ADDR, a});
      host_en <= 1'b0;
      chk("read oe", 1'b1, port_oe);
      chk("read data", {`SDV_TAG_RDATA, exp}, port_q);
      port_edge(1'b0, 1'b1, 1'b0, 10'h000);
      chk("release oe", 1'b0, port_oe);
    end
  endtask
  task reg_write(input [7:0] a, input [7:0] v);
    begin
      port_edge(1'b0, 1'b0, 1'b1, {`SDV_TAG_ADDR, a});
      port_edge(1'b0, 1'b0, 1'b1, {`SDV_TAG_WDATA, v});
      host_en <= 1'b0;
    end
  endtask
  task expect_line;
    integer n;
    begin
      n = 0;
      while (seen !== 1'b1 && n < 600) begin
        @(posedge clk);
        n = n + 1;
      end
      chk("line words", 1'b1, seen);
    end
  endtask
  // undo NRZI and scrambling, keep the last 40 data bits
  always @(posedge clk) begin : mon
    reg s;
    reg d;
    s = serial_line_out ^ prev_sdo;
    d = s ^ sh[3] ^ sh[8];
    sh = {sh[7:0], s};
    prev_sdo = serial_line_out;
    win = {d, win[39:1]};
    if (win === want) seen = 1'b1;
    if (anc_valid === 1'b1) begin
      anc_cnt = anc_cnt + 1;
      anc_last = anc_data;
    end
    if (ready === 1'b0) saw_full = 1'b1;
    cycles = cycles + 1;
    if (cycles == 8000) begin
      fails = fails + 1;
      print_verdict;
    end
  end
  initial begin
    fails = 0;
    checks_done = 0;
    cycles = 0;
    anc_cnt = 0;
    seed = 32'hF955;
    sh = 9'h000;
    prev_sdo = 1'b0;
    win = 40'h0000000000;
    want = 40'hFFFFFFFFFF;
    seen = 1'b0;
    saw_full = 1'b0;
    vblank = 1'b0;
    rst_n = 1'b0;
    pll = 1'b0;
    aclk = 1'b0;
    tgt = 1'b0;
    dir = 1'b0;
    host_en = 1'b0;
    host_data = 10'h000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("ready", 1'b1, ready);
    chk("lock", 1'b0, lock);
    reg_read(`SDV_REG_FMT_CTRL, `SDV_FMT_CTRL_RST);
    reg_read(`SDV_REG_ANC_CFG, {5'h00, `SDV_ANC_CFG_RST});
    reg_read(`SDV_REG_PIC_INFO, {6'h00, `SDV_PIC_INFO_RST});
    reg_read(8'h7E, 8'h00);
    seed = xs(seed);
    reg_write(`SDV_REG_PIC_INFO, {6'h00, seed[1:0]});
    reg_read(`SDV_REG_PIC_INFO, {6'h00, seed[1:0]});
    reg_write(`SDV_REG_PIC_INFO, 8'h00);
    reg_write(`SDV_REG_ANC_CFG, 8'h00);
    reg_read(`SDV_REG_ANC_CFG, 8'h00);
    $display("test registers done");
    for (i = 0; i < 3; i = i + 1) begin
      seed = xs(seed);
      port_edge(1'b1, 1'b0, 1'b1, seed[9:0]);
      chk("anc count", i + 1, anc_cnt);
      chk("anc word", seed[9:0], anc_last);
    end
    port_edge(1'b1, 1'b1, 1'b1, 10'h155);
    port_edge(1'b1, 1'b0, 1'b1, {`SDV_TAG_ADDR, `SDV_REG_PIC_INFO});
    port_edge(1'b1, 1'b0, 1'b1, 10'h303);
    chk("anc count", 5, anc_cnt);
    reg_read(`SDV_REG_PIC_INFO, 8'h00);
    $display("test ancillary done");
    pll <= 1'b1;
    repeat (2) @(posedge clk);
    chk("lock idle", 1'b0, lock);
    reg_write(`SDV_REG_FMT_CTRL, {3'h0, `SDV_FMT_SD525});
    chk("lock forced", 1'b1, lock);
    pll <= 1'b0;
    repeat (2) @(posedge clk);
    chk("lock no pll", 1'b0, lock);
    pll <= 1'b1;
    $display("test lock done");
    want = {clip10(10'h3FB), clip10(10'h3FD), clip10(10'h002),
      clip10(10'h004)};
    seen = 1'b0;
    i_sdv_video_src.send(20'h00004);
    i_sdv_video_src.send(20'h00002);
    i_sdv_video_src.send(20'h003FD);
    i_sdv_video_src.send(20'h003FB);
    expect_line;
    $display("test sd line done");
    reg_write(`SDV_REG_FMT_CTRL, {3'h0, `SDV_FMT_1125_30});
    for (i = 0; i < 14; i = i + 1) begin
      seed = xs(seed);
      w0 = w1;
      w1 = seed[19:0];
      vblank <= seed[20];
      i_sdv_video_src.send(w1);
    end
    want = {clip10(w1[19:10]), clip10(w1[9:0]), clip10(w0[19:10]),
      clip10(w0[9:0])};
    seen = 1'b0;
    expect_line;
    chk("fifo refused", 1'b1, saw_full);
    chk("ready drained", 1'b1, ready);
    $display("test hd line done");
    print_verdict;
  end
endmodule
bind sdv_serializer sdv_serializer_chk i_sdv_serializer_chk (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
  .i_pixel_word_clock(i_pixel_word_clock), .i_video_in_bus(i_video_in_bus),
  .o_video_ready(o_video_ready), .i_vert_blank(i_vert_blank),
  .i_pll_locked(i_pll_locked), .i_port_clock(i_port_clock),
  .i_port_target(i_port_target), .i_port_dir(i_port_dir),
  .i_port_data(i_port_data), .o_port_data(o_port_data),
  .o_port_oe(o_port_oe), .o_anc_valid(o_anc_valid),
  .o_anc_data(o_anc_data), .o_serial_line_out(o_serial_line_out),
  .o_lock_detect(o_lock_detect));

// [tb/sdv_video_src.sv]
// Purpose: parallel video source facing the serializer
// Assumes: send is called just after a core clock edge
// Notes: bus shows the inverse word once its hold has run out
`timescale 1ns/10ps
module sdv_video_src (
  input wire i_core_clk,
  input wire i_ready,
  output reg o_pixel_word_clock,
  output reg [19:0] o_video_in_bus
);
  initial begin
    o_pixel_word_clock = 1'b0;
    o_video_in_bus = 20'h00000;
  end
  // wait for room, then one clock rise per word, 7 cycles apart
  task send(input [19:0] w);
    integer n;
    begin
      n = 0;
      while (i_ready !== 1'b1 && n < 2000) begin
        @(posedge i_core_clk);
        n = n + 1;
      end
      o_video_in_bus <= w;
      o_pixel_word_clock <= 1'b1;
      repeat (4) @(posedge i_core_clk);
      o_pixel_word_clock <= 1'b0;
      o_video_in_bus <= ~w;
      repeat (3) @(posedge i_core_clk);
    end
  endtask
endmodule
